// file: logic/xo_cfg.svh
`ifndef XO_CFG_SVH
`define XO_CFG_SVH

// Register byte addresses
`define XO_CTRL_ADDR        8'h00
`define XO_IRQ_STATUS_ADDR  8'h04
`define XO_IRQ_MASK_ADDR    8'h08

// Control register fields
`define XO_CTRL_ENABLE_BIT  7
`define XO_CTRL_RSVD6_BIT   6
`define XO_CTRL_STOPKEEP_BIT 5
`define XO_CTRL_OSEL_BIT    4
`define XO_CTRL_RSVD3_BIT   3
`define XO_CTRL_BAND_BIT    2
`define XO_CTRL_GAIN_BIT    1
`define XO_CTRL_DONE_BIT    0
`define XO_CTRL_RESET       8'h00
`define XO_CTRL_WMASK       8'hb6

// Interrupt status and mask fields
`define XO_IRQ_DONE_BIT     0
`define XO_IRQ_LOST_BIT     1
`define XO_IRQ_WIDTH        2
`define XO_IRQ_RESET        2'h0

// Stabilisation count in crystal clock cycles
`define XO_STABLE_CYCLES    4096

`endif

// file: logic/xo_pkg.sv
`default_nettype none

package xo_pkg;

    typedef enum logic [1:0]
    {
        XO_OFF,
        XO_STARTUP,
        XO_STABLE,
        XO_EXTERNAL
    } xo_state_type;

    typedef enum logic [1:0]
    {
        XO_LF_LOW_POWER,
        XO_LF_HIGH_GAIN,
        XO_HF_LOW_POWER,
        XO_HF_HIGH_GAIN
    } xo_mode_type;

endpackage

`default_nettype wire

// file: logic/xo_ctrl.sv
// Notes on behaviour
// - Control register is 8 bits at offset zero, reset to all zeros.
// - Bit 7 is software enable; clock generator request also enables.
// - Bits 6 and 3 read zero and ignore writes.
// - Bit 5 keeps oscillator running in stop mode while enabled.
// - Active when request set, or enabled and not stopped or kept on.
// - Bit 4 selects external pin clock (0) or crystal clock (1).
// - Bit 2 selects low 32 kHz range (0) or 4-24 MHz range (1).
// - Bit 1 selects low-power (0) or high-gain (1) amplifier.
// - Bit 0 reads 1 once the startup count has completed.
// - Inactive unit goes off; crystal and output clocks held static.
// - Activation with crystal selected enters startup and counts crystal edges.
// - After 4096 crystal cycles go stable and raise count complete.
// - Output clock gated off until 4096 cycles, then passes crystal clock.
// - Active with external selected: pin clock buffered to output.
// - Range and gain bits pick one of four oscillator modes.
`timescale 1ns/100ps
`default_nettype none
`include "xo_cfg.svh"

module xo_ctrl
#(
    parameter int STABLE_CYCLES = `XO_STABLE_CYCLES
)
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // System controls
    input  wire logic        clock_gen_enable_request_i,
    input  wire logic        stop_mode_i,
    // Clock pins
    input  wire logic        crystal_clock_i,
    input  wire logic        clock_input_pin_i,
    // Oscillator outputs
    output logic             gated_output_clock_o,
    output logic             amp_enable_o,
    output logic [1:0]       osc_mode_o,
    output logic             count_complete_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////
    localparam int CNT_W = $clog2(STABLE_CYCLES + 1);

    logic [7:0]               ctrl_q;
    logic [`XO_IRQ_WIDTH-1:0] irq_status_q;
    logic [`XO_IRQ_WIDTH-1:0] irq_mask_q;
    logic                     done_meta_q;
    logic                     done_sync_q;
    logic                     done_sync_prev_q;
    logic                     active_prev_q;
    logic                     drive_output_pin_s_q;
    logic                     drive_output_pin_prev_q;
    logic                     ext_s_q;
    logic [CNT_W-1:0]         count_q;
    xo_pkg::xo_state_type     state_q;

    logic                     osc_active;
    logic                     drive_output_pin_edge;
    logic                     bus_req;
    logic                     wr_take;
    logic                     wr_lane0;
    logic [`XO_IRQ_WIDTH-1:0] irq_event;
    logic                     ctrl_hit;
    logic                     status_hit;
    logic                     mask_hit;
    logic                     wr_ctrl;
    logic                     wr_status;
    logic                     wr_mask;
    logic [7:0]               ctrl_wr;
    logic [31:0]              read_word;
    logic                     count_last;
    xo_pkg::xo_mode_type      mode_d;

    assign bus_req  = avs_read_i | avs_write_i;
    assign wr_take  = avs_write_i & ~avs_waitrequest_o;
    assign wr_lane0 = wr_take & avs_byteenable_i[0];

    // Address decode and write-data masking
    assign ctrl_hit   = (avs_address_i == `XO_CTRL_ADDR);
    assign status_hit = (avs_address_i == `XO_IRQ_STATUS_ADDR);
    assign mask_hit   = (avs_address_i == `XO_IRQ_MASK_ADDR);
    assign wr_ctrl    = wr_lane0 & ctrl_hit;
    assign wr_status  = wr_lane0 & status_hit;
    assign wr_mask    = wr_lane0 & mask_hit;
    assign ctrl_wr    = avs_writedata_i[7:0] & `XO_CTRL_WMASK;

    // Effective enable: the clock generator request overrides all
    always_comb
    begin
        if (clock_gen_enable_request_i)
            osc_active = 1'b1;
        else if (!ctrl_q[`XO_CTRL_ENABLE_BIT])
            osc_active = 1'b0;
        else if (stop_mode_i)
            osc_active = ctrl_q[`XO_CTRL_STOPKEEP_BIT];
        else
            osc_active = 1'b1;
    end

    assign drive_output_pin_edge = drive_output_pin_s_q & ~drive_output_pin_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then the request is taken
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            avs_waitrequest_o <= 1'b1;
        else if (bus_req && avs_waitrequest_o)
            avs_waitrequest_o <= 1'b0;
        else
            avs_waitrequest_o <= 1'b1;
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb
    begin
        if (ctrl_hit)
            read_word = {24'h0, ctrl_q};
        else if (status_hit)
            read_word = {30'h0, irq_status_q};
        else if (mask_hit)
            read_word = {30'h0, irq_mask_q};
        else
            read_word = 32'h0;
    end

    // Latched on the waited cycle so it stands while wait is low
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            avs_readdata_o <= 32'h0;
        else if (avs_read_i && avs_waitrequest_o)
            avs_readdata_o <= read_word;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register; reserved bits and done bit are not writable
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            ctrl_q <= `XO_CTRL_RESET;
        else
        begin
            if (wr_ctrl)
                ctrl_q[7:1] <= ctrl_wr[7:1];
            // Done bit drops at once when the unit is disabled
            ctrl_q[`XO_CTRL_DONE_BIT] <= done_sync_q & osc_active;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            irq_mask_q <= `XO_IRQ_RESET;
        else if (wr_mask)
            irq_mask_q <= avs_writedata_i[`XO_IRQ_WIDTH-1:0];
    end

    // Events: startup completed, and a running oscillator lost
    assign irq_event[`XO_IRQ_DONE_BIT] = done_sync_q & ~done_sync_prev_q;
    assign irq_event[`XO_IRQ_LOST_BIT] = active_prev_q & ~osc_active;

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            irq_status_q <= `XO_IRQ_RESET;
        else if (wr_status)
            irq_status_q <= (irq_status_q
                & ~avs_writedata_i[`XO_IRQ_WIDTH-1:0]) | irq_event;
        else
            irq_status_q <= irq_status_q | irq_event;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_status_q & irq_mask_q);
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling; the crystal must run below half the system clock,
    // otherwise sampled edges are lost and the count runs long
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            drive_output_pin_s_q    <= 1'b0;
            drive_output_pin_prev_q <= 1'b0;
            ext_s_q     <= 1'b0;
        end
        else
        begin
            drive_output_pin_s_q    <= crystal_clock_i;
            drive_output_pin_prev_q <= drive_output_pin_s_q;
            ext_s_q     <= clock_input_pin_i;
        end
    end

    // Previous enable, for the oscillator-lost event
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            active_prev_q <= 1'b0;
        else
            active_prev_q <= osc_active;
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator state machine; leaving the external state for the
    // crystal always passes through startup, so the count restarts
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            state_q <= xo_pkg::XO_OFF;
        else if (!osc_active)
            state_q <= xo_pkg::XO_OFF;
        else if (!ctrl_q[`XO_CTRL_OSEL_BIT])
            state_q <= xo_pkg::XO_EXTERNAL;
        else
        begin
            case (state_q)
                xo_pkg::XO_OFF,
                xo_pkg::XO_EXTERNAL:
                    state_q <= xo_pkg::XO_STARTUP;
                xo_pkg::XO_STARTUP:
                    if (count_complete_o)
                        state_q <= xo_pkg::XO_STABLE;
                default:
                    state_q <= state_q;
            endcase
        end
    end

    assign count_last = (count_q == CNT_W'(STABLE_CYCLES - 1));

    // Stabilisation counter on sampled crystal edges
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            count_q <= '0;
        else if (state_q != xo_pkg::XO_STARTUP
                 && state_q != xo_pkg::XO_STABLE)
            count_q <= '0;
        else if (drive_output_pin_edge && !count_complete_o)
            count_q <= count_q + CNT_W'(1);
    end

    // Completion holds until the unit leaves startup or stable
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            count_complete_o <= 1'b0;
        else if (state_q != xo_pkg::XO_STARTUP
                 && state_q != xo_pkg::XO_STABLE)
            count_complete_o <= 1'b0;
        else if (drive_output_pin_edge && count_last)
            count_complete_o <= 1'b1;
    end

    // Two-stage synchroniser ahead of the done flag
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            done_meta_q <= 1'b0;
            done_sync_q <= 1'b0;
        end
        else
        begin
            done_meta_q <= count_complete_o;
            done_sync_q <= done_meta_q;
        end
    end

    // Delayed copy for the startup-done event
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            done_sync_prev_q <= 1'b0;
        else
            done_sync_prev_q <= done_sync_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output clock and amplifier controls
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            gated_output_clock_o <= 1'b0;
        else if (state_q == xo_pkg::XO_STABLE)
            gated_output_clock_o <= drive_output_pin_s_q;
        else if (state_q == xo_pkg::XO_EXTERNAL)
            gated_output_clock_o <= ext_s_q;
        else
            gated_output_clock_o <= 1'b0;
    end

    // Amplifier mode from range and gain
    always_comb
    begin
        case ({ctrl_q[`XO_CTRL_BAND_BIT], ctrl_q[`XO_CTRL_GAIN_BIT]})
            2'b00:
                mode_d = xo_pkg::XO_LF_LOW_POWER;
            2'b01:
                mode_d = xo_pkg::XO_LF_HIGH_GAIN;
            2'b10:
                mode_d = xo_pkg::XO_HF_LOW_POWER;
            default:
                mode_d = xo_pkg::XO_HF_HIGH_GAIN;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            amp_enable_o <= 1'b0;
        else
            amp_enable_o <= osc_active & ctrl_q[`XO_CTRL_OSEL_BIT];
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            osc_mode_o <= xo_pkg::XO_LF_LOW_POWER;
        else
            osc_mode_o <= mode_d;
    end

endmodule

`default_nettype wire

// file: bench/xo_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module xo_chk
#(
    parameter int STABLE_CYCLES = 4096
)
(
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        amp_enable_o,
    input wire logic [1:0]  osc_mode_o,
    input wire logic        count_complete_o,
    input wire logic        gated_output_clock_o
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (!rst_b_i);
////////////////////////////////////////////////////////////////////////////
chk_wait_taken: assert property ((avs_read_i || avs_write_i)
    && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("wait low too long");
chk_wait_idle: assert property (!avs_read_i && !avs_write_i
    |=> avs_waitrequest_o) else $error("answer without request");
chk_byte_wide: assert property (avs_read_i && !avs_waitrequest_o
    |-> avs_readdata_o[31:8] == 24'h000000) else $error("upper bits set");
chk_rsvd_zero: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i == 8'h00 |-> !avs_readdata_o[6] && !avs_readdata_o[3])
    else $error("reserved bit set");
chk_done_active: assert property ($rose(count_complete_o)
    |-> amp_enable_o) else $error("count done while off");
chk_gate_off: assert property ((amp_enable_o && !count_complete_o)[*4]
    |-> !gated_output_clock_o) else $error("output before stable");
chk_done_clear: assert property (!amp_enable_o[*2]
    |-> !count_complete_o) else $error("count done kept when off");
chk_mode_bits: assert property (avs_write_i && !avs_waitrequest_o
    && avs_address_i == 8'h00 && avs_byteenable_i[0]
    |-> ##2 osc_mode_o == $past(avs_writedata_i[2:1], 2))
    else $error("mode not from range and gain");
endmodule
`default_nettype wire

// file: bench/xo_drive_output_pin.sv
`timescale 1ns/100ps
`default_nettype none
module xo_drive_output_pin
#(
    parameter int DRIVE_OUTPUT_PIN_HALF_NS = 40,
    parameter int PIN_HALF_NS  = 30
)
(
    // Amplifier drive from the unit
    input  wire logic amp_enable_i,
    // Clock sources
    output logic      crystal_clock_o,
    output logic      clock_input_pin_o
);
initial
begin
    crystal_clock_o = 1'b0;
    clock_input_pin_o = 1'b0;
end
// Crystal swings only while the amplifier drives it
always #(DRIVE_OUTPUT_PIN_HALF_NS) crystal_clock_o = amp_enable_i & ~crystal_clock_o;
// External source runs free
always #(PIN_HALF_NS) clock_input_pin_o = ~clock_input_pin_o;
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int STABLE = 16;
    logic        ref_clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        clock_gen_enable_request_i = 1'b0;
    logic        stop_mode_i = 1'b0;
    wire         crystal_clock_i;
    wire         clock_input_pin_i;
    logic        gated_output_clock_o;
    logic        amp_enable_o;
    logic [1:0]  osc_mode_o;
    logic        count_complete_o;
    logic        irq_o;
    int          n_fail = 0;
    int          num_checks = 0;
    int          xcnt = 0;
xo_ctrl #(.STABLE_CYCLES(STABLE)) i_dut (.*);
xo_drive_output_pin u_src (.amp_enable_i(amp_enable_o), .crystal_clock_o(crystal_clock_i),
    .clock_input_pin_o(clock_input_pin_i));
always #5 ref_clk_i = ~ref_clk_i;
// Crystal edges seen in this enable, up to the count completing
always @(posedge crystal_clock_i or negedge amp_enable_o)
    xcnt <= !amp_enable_o ? 0 : xcnt + !count_complete_o;
////////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= 4'h1;
    avs_write_i <= w;
    avs_read_i <= !w;
    do
    begin
        @(posedge ref_clk_i);
    end
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
endtask
task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
endtask
task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, e}, q);
endtask
task automatic wait_cc(input logic v);
    int n;
    n = 0;
    while (count_complete_o !== v && n < 400)
    begin
        @(posedge ref_clk_i);
        n++;
    end
    chk("count_complete", {31'h0, v}, {31'h0, count_complete_o});
endtask
// Counts output changes over 40 cycles
task automatic toggles(input string nm, input int lo, input int hi);
    int e;
    logic p;
    e = 0;
    p = gated_output_clock_o;
    repeat (40)
    begin
        @(posedge ref_clk_i);
        e += (gated_output_clock_o !== p);
        p = gated_output_clock_o;
    end
    chk(nm, 32'h1, {31'h0, e >= lo && e <= hi});
endtask
task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////
initial
begin
    #(20000 * 10);
    n_fail++;
    final_report();
end
initial
begin
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rchk("ctrl reset", 8'h00, 8'h00);
    wreg(8'h0c, 8'hff);
    rchk("unmapped", 8'h0c, 8'h00);
    rchk("irq status", 8'h04, 8'h00);
    $display("test reset and map done");
    for (int m = 0; m < 4; m++)
    begin
        wreg(8'h00, 8'h78 | 8'(m << 1));
        rchk("ctrl fields", 8'h00, 8'h30 | 8'(m << 1));
        chk("osc_mode", 32'(m), {30'h0, osc_mode_o});
    end
    $display("test fields and modes done");
    wreg(8'h08, 8'h03);
    wreg(8'h00, 8'hb6);
    rchk("done early", 8'h00, 8'hb6);
    wait_cc(1'b1);
    chk("crystal edges", STABLE, xcnt);
    toggles("crystal out", 8, 12);
    rchk("done", 8'h00, 8'hb7);
    chk("irq set", 32'h1, {31'h0, irq_o});
    wreg(8'h08, 8'h00);
    rchk("status sticky", 8'h04, 8'h01);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wreg(8'h08, 8'h03);
    wreg(8'h04, 8'h01);
    rchk("status clear", 8'h04, 8'h00);
    chk("irq clear", 32'h0, {31'h0, irq_o});
    $display("test startup done");
    stop_mode_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    chk("stop keep", 32'h1, {31'h0, amp_enable_o});
    wreg(8'h00, 8'h96);
    wait_cc(1'b0);
    rchk("done cleared", 8'h00, 8'h96);
    rchk("lost status", 8'h04, 8'h02);
    wreg(8'h04, 8'h03);
    clock_gen_enable_request_i <= 1'b1;
    wait_cc(1'b1);
    chk("recount", STABLE, xcnt);
    $display("test stop and request done");
    clock_gen_enable_request_i <= 1'b0;
    stop_mode_i <= 1'b0;
    wreg(8'h00, 8'h06);
    repeat (6) @(posedge ref_clk_i);
    toggles("off out", 0, 0);
    chk("off level", 32'h0, {31'h0, gated_output_clock_o});
    wreg(8'h00, 8'h86);
    repeat (6) @(posedge ref_clk_i);
    toggles("external out", 11, 15);
    chk("amp off", 32'h0, {31'h0, amp_enable_o});
    $display("test off and external done");
    final_report();
end
endmodule
bind xo_ctrl xo_chk #(.STABLE_CYCLES(STABLE_CYCLES)) u_chk (.*);
`default_nettype wire
